/* rtl/ttrs_defs.svh */
`ifndef TTRS_DEFS_SVH
`define TTRS_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TTRS_OFS_A_ITI      12'h024
`define TTRS_OFS_A_BRK      12'h028
`define TTRS_OFS_B_ITI      12'h02C
`define TTRS_OFS_B_BRK      12'h030
`define TTRS_ADDR_W         12

// ****************************************
// Reset values
// ****************************************
`define TTRS_RST_A_ITI      32'h39393939
`define TTRS_RST_A_BRK      32'h39393939
`define TTRS_RST_B_ITI      32'h15151515
`define TTRS_RST_B_BRK      32'h00000000

// ****************************************
// Field layout
// ****************************************
`define TTRS_LOCK_BIT       31
`define TTRS_SEL_W          7
`define TTRS_FIELD_STRIDE   8
`define TTRS_NUM_OUT        4
`define TTRS_NUM_REG        4
`define TTRS_NUM_SRC        128
`define TTRS_WRITABLE_MASK  32'hFF7F7F7F
`define TTRS_ZERO32         32'h00000000

`endif

/* rtl/ttrs_pkg.sv */
package ttrs_pkg;
`include "ttrs_defs.svh"

    typedef logic [`TTRS_SEL_W-1:0] ttrs_sel_type;

    typedef struct packed {
        ttrs_sel_type sel3;
        ttrs_sel_type sel2;
        ttrs_sel_type sel1;
        ttrs_sel_type sel0;
    } ttrs_sels_type;

    typedef struct packed {
        logic                      psel;
        logic                      penable;
        logic                      pwrite;
        logic [`TTRS_ADDR_W-1:0]   paddr;
        logic [31:0]               pwdata;
        logic [3:0]                pstrb;
    } ttrs_apb_req_type;

    typedef enum logic [1:0] {
        TTRS_REG_A_ITI,
        TTRS_REG_A_BRK,
        TTRS_REG_B_ITI,
        TTRS_REG_B_BRK
    } ttrs_reg_type;

endpackage

/* rtl/ttrs_lock_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ttrs_defs.svh"
module ttrs_lock_reg
    import ttrs_pkg::*;
#(
    parameter logic [31:0] RESET_VALUE = `TTRS_ZERO32
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] value
);
    logic [31:0] reg_q;
    logic [31:0] reg_d;

    always_comb begin
        reg_d = reg_q;
        // Lock blocks every write, including one that would clear the lock
        if (wr_en && !reg_q[`TTRS_LOCK_BIT]) begin
            // Reserved bits keep their reset value whatever software writes
            reg_d = (wr_data & `TTRS_WRITABLE_MASK) | (RESET_VALUE & ~`TTRS_WRITABLE_MASK);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_q <= RESET_VALUE;
        end else begin
            reg_q <= reg_d;
        end
    end

    assign value = reg_q;
endmodule // ttrs_lock_reg
`default_nettype wire

/* rtl/ttrs_src_mux.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ttrs_defs.svh"
module ttrs_src_mux
    import ttrs_pkg::*;
(
    input  wire logic [`TTRS_NUM_SRC-1:0] sources,
    input  wire logic [31:0]              sel_word,
    output logic      [`TTRS_NUM_OUT-1:0] routed
);
    genvar g;
    generate
        for (g = 0; g < `TTRS_NUM_OUT; g++) begin : g_out
            // Field n sits at bits 8n+6:8n
            assign routed[g] = sources[sel_word[g*`TTRS_FIELD_STRIDE +: `TTRS_SEL_W]];
        end
    endgenerate
endmodule // ttrs_src_mux
`default_nettype wire

/* rtl/ttrs_top.sv */
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ttrs_defs.svh"
// Notes on behaviour
// - Bit 31 lock sets, clears only on reset
// - Writes ignored while register lock is set
// - Four 7-bit fields, bytes three to zero
// - Timer A trigger register feeds trigger inputs
// - Break registers feed each timer's break inputs
// - Timer B trigger register feeds trigger inputs
// - Reset values 39393939, 39393939, 15151515, zero
// - Registers decode at 0x24, 0x28, 0x2C, 0x30
module ttrs_top
    import ttrs_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`TTRS_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic                           pready,
    output logic      [31:0]               prdata,
    output logic                           pslverr,
    input  wire logic [`TTRS_NUM_SRC-1:0]  trigger_sources,
    output logic      [`TTRS_NUM_OUT-1:0]  timer_a_internal_trigger_in,
    output logic      [`TTRS_NUM_OUT-1:0]  timer_a_break_in,
    output logic      [`TTRS_NUM_OUT-1:0]  timer_b_internal_trigger_in,
    output logic      [`TTRS_NUM_OUT-1:0]  timer_b_break_in
);
    // ****************************************
    // Bus decode
    // ****************************************
    ttrs_apb_req_type req;
    logic [`TTRS_NUM_REG-1:0] hit;
    logic [`TTRS_NUM_REG-1:0] wr_en;
    logic                     mapped;
    logic                     setup;
    logic [31:0]              regs [`TTRS_NUM_REG];
    logic [31:0]              rd_mux;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata, pstrb: pstrb};

    always_comb begin
        hit = '0;
        hit[TTRS_REG_A_ITI] = (req.paddr == `TTRS_OFS_A_ITI);
        hit[TTRS_REG_A_BRK] = (req.paddr == `TTRS_OFS_A_BRK);
        hit[TTRS_REG_B_ITI] = (req.paddr == `TTRS_OFS_B_ITI);
        hit[TTRS_REG_B_BRK] = (req.paddr == `TTRS_OFS_B_BRK);
    end

    assign mapped = |hit;
    // Answer is registered, so the access phase always lasts one cycle
    assign setup  = req.psel && !req.penable;

    // Partial-strobe writes are dropped, since only word access is defined
    genvar r;
    generate
        for (r = 0; r < `TTRS_NUM_REG; r++) begin : g_wr
            assign wr_en[r] = setup && req.pwrite && hit[r] && (&req.pstrb);
        end
    endgenerate

    always_comb begin
        rd_mux = `TTRS_ZERO32;
        for (int i = 0; i < `TTRS_NUM_REG; i++) begin
            if (hit[i]) begin
                rd_mux = regs[i];
            end
        end
    end

    // ****************************************
    // Selector registers
    // ****************************************
    ttrs_lock_reg #(.RESET_VALUE(`TTRS_RST_A_ITI)) u_a_iti (
        .sys_clk (sys_clk), .rst (rst), .wr_en (wr_en[TTRS_REG_A_ITI]),
        .wr_data (req.pwdata), .value (regs[TTRS_REG_A_ITI])
    );
    ttrs_lock_reg #(.RESET_VALUE(`TTRS_RST_A_BRK)) u_a_brk (
        .sys_clk (sys_clk), .rst (rst), .wr_en (wr_en[TTRS_REG_A_BRK]),
        .wr_data (req.pwdata), .value (regs[TTRS_REG_A_BRK])
    );
    ttrs_lock_reg #(.RESET_VALUE(`TTRS_RST_B_ITI)) u_b_iti (
        .sys_clk (sys_clk), .rst (rst), .wr_en (wr_en[TTRS_REG_B_ITI]),
        .wr_data (req.pwdata), .value (regs[TTRS_REG_B_ITI])
    );
    ttrs_lock_reg #(.RESET_VALUE(`TTRS_RST_B_BRK)) u_b_brk (
        .sys_clk (sys_clk), .rst (rst), .wr_en (wr_en[TTRS_REG_B_BRK]),
        .wr_data (req.pwdata), .value (regs[TTRS_REG_B_BRK])
    );

    // ****************************************
    // Routing
    // ****************************************
    logic [`TTRS_NUM_OUT-1:0] route [`TTRS_NUM_REG];

    generate
        for (r = 0; r < `TTRS_NUM_REG; r++) begin : g_mux
            ttrs_src_mux u_mux (
                .sources  (trigger_sources),
                .sel_word (regs[r]),
                .routed   (route[r])
            );
        end
    endgenerate

    // ****************************************
    // Output and bus answer registers
    // ****************************************
    logic                     pready_q, pready_d;
    logic [31:0]              prdata_q, prdata_d;
    logic                     pslverr_q, pslverr_d;
    logic [`TTRS_NUM_OUT-1:0] a_iti_q, a_iti_d;
    logic [`TTRS_NUM_OUT-1:0] a_brk_q, a_brk_d;
    logic [`TTRS_NUM_OUT-1:0] b_iti_q, b_iti_d;
    logic [`TTRS_NUM_OUT-1:0] b_brk_q, b_brk_d;

    always_comb begin
        pready_d  = setup;
        prdata_d  = (setup && !req.pwrite) ? rd_mux : `TTRS_ZERO32;
        // Locked writes are silently ignored, not flagged as errors
        pslverr_d = setup && !mapped;
        a_iti_d   = route[TTRS_REG_A_ITI];
        a_brk_d   = route[TTRS_REG_A_BRK];
        b_iti_d   = route[TTRS_REG_B_ITI];
        b_brk_d   = route[TTRS_REG_B_BRK];
    end

    // Outputs registered: routed triggers lag their sources by one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= `TTRS_ZERO32;
            pslverr_q <= 1'b0;
            a_iti_q   <= '0;
            a_brk_q   <= '0;
            b_iti_q   <= '0;
            b_brk_q   <= '0;
        end else begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            a_iti_q   <= a_iti_d;
            a_brk_q   <= a_brk_d;
            b_iti_q   <= b_iti_d;
            b_brk_q   <= b_brk_d;
        end
    end

    assign pready                      = pready_q;
    assign prdata                      = prdata_q;
    assign pslverr                     = pslverr_q;
    assign timer_a_internal_trigger_in = a_iti_q;
    assign timer_a_break_in            = a_brk_q;
    assign timer_b_internal_trigger_in = b_iti_q;
    assign timer_b_break_in            = b_brk_q;
endmodule // ttrs_top
`default_nettype wire

/* tb/ttrs_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Timer side
// ****
module ttrs_timer_model
    import ttrs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic [15:0] trig_in,
    output logic      [15:0] seen_q
);
    // Timers resample their inputs, so what they see lags the router by a clock
    always_ff @(posedge sys_clk) begin
        seen_q <= trig_in;
    end
endmodule // ttrs_timer_model
`default_nettype wire

/* tb/ttrs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module ttrs_monitor
    import ttrs_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic [11:0]  paddr,
    input  wire logic         pready,
    input  wire logic [31:0]  prdata,
    input  wire logic         pslverr,
    input  wire logic [127:0] trigger_sources,
    input  wire logic [3:0]   timer_a_internal_trigger_in,
    input  wire logic [3:0]   timer_a_break_in,
    input  wire logic [3:0]   timer_b_internal_trigger_in,
    input  wire logic [3:0]   timer_b_break_in
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_ans; psel && !penable |=> pready && pslverr == !($past(paddr) inside {12'h024, 12'h028, 12'h02C, 12'h030}); endproperty
    a_ans: assert property (p_ans) else $error("bad answer to setup");
    property p_quiet; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_quiet: assert property (p_quiet) else $error("read bus not quiet");
    property p_single; pready |=> !pready; endproperty
    a_single: assert property (p_single) else $error("ready held too long");
    property p_res; pready |-> (prdata & 32'h00808080) == 32'h0; endproperty
    a_res: assert property (p_res) else $error("reserved bit set");
    property p_a_iti; &trigger_sources |=> &timer_a_internal_trigger_in; endproperty
    a_a_iti: assert property (p_a_iti) else $error("timer a trigger not routed");
    property p_a_brk; &trigger_sources |=> &timer_a_break_in; endproperty
    a_a_brk: assert property (p_a_brk) else $error("timer a break not routed");
    property p_b_iti; &trigger_sources |=> &timer_b_internal_trigger_in; endproperty
    a_b_iti: assert property (p_b_iti) else $error("timer b trigger not routed");
    property p_b_brk; !(|trigger_sources) |=> !(|timer_b_break_in); endproperty
    a_b_brk: assert property (p_b_brk) else $error("timer b break not routed");
endmodule // ttrs_monitor
bind ttrs_top ttrs_monitor u_mon (.sys_clk, .rst, .psel, .penable, .paddr, .pready, .prdata, .pslverr,
    .trigger_sources, .timer_a_internal_trigger_in, .timer_a_break_in, .timer_b_internal_trigger_in,
    .timer_b_break_in);
`default_nettype wire

/* tb/test_timer_trigger_route_select.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module test_timer_trigger_route_select
    import ttrs_pkg::*;
;
    logic         sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0, r = 32'h77C9, sh [4];
    logic [32:0]  q [$];
    logic [3:0]   pstrb = 4'hF;
    logic [127:0] src = '0;
    logic         pready, pslverr;
    logic [31:0]  prdata;
    wire  [15:0]  tq;
    logic [15:0]  seen;
    int           mismatches = 0, total_checks = 0, i;
    ttrs_top u_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
        .pslverr, .trigger_sources(src), .timer_a_internal_trigger_in(tq[3:0]), .timer_a_break_in(tq[7:4]),
        .timer_b_internal_trigger_in(tq[11:8]), .timer_b_break_in(tq[15:12]));
    ttrs_timer_model u_tm (.sys_clk, .trig_in(tq), .seen_q(seen));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end
    function logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [11:0] ad(input int k);
        return 12'h024 + 12'(4 * k);
    endfunction
    task chk(input string n, input logic [32:0] e, input logic [32:0] s);
        total_checks++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", n, e, s);
            mismatches++;
        end
    endtask
    // Idle cycle after each transfer keeps psel from being cleared and set in one step
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        pstrb <= s;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        // Unmapped offsets answer with an error and zero data
        q.push_back({!(a inside {12'h024, 12'h028, 12'h02C, 12'h030}), e});
        xf(1'b0, a, 32'h0, 4'hF);
    endtask
    task wr(input int k, input logic [31:0] d, input logic [3:0] s = 4'hF);
        xf(1'b1, ad(k), d, s);
        if (!sh[k][31] && s == 4'hF) sh[k] = d & 32'hFF7F7F7F;
    endtask
    task rs;
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        sh = '{32'h39393939, 32'h39393939, 32'h15151515, 32'h00000000};
        @(posedge sys_clk);
    endtask
    task rc(input logic ones);
        logic [15:0] e;
        for (int k = 0; k < 4; k++) begin
            r = nx(r);
            src[32 * k +: 32] <= ones ? 32'hFFFFFFFF : r;
        end
        repeat (3) @(posedge sys_clk);
        for (int k = 0; k < 16; k++) e[k] = src[sh[k / 4][8 * (k % 4) +: 7]];
        chk("routed", {17'h0, e}, {17'h0, seen});
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            chk("read data", q.pop_front(), {pslverr, prdata});
        end
    end
    initial begin
        rs();
        for (i = 0; i < 4; i++) rd(ad(i), sh[i]);
        rd(12'h034, 32'h0);
        $display("reset values done");
        for (i = 0; i < 4; i++) begin
            r = nx(r);
            wr(i, r & 32'h7F7F7F7F);
            rd(ad(i), sh[i]);
            wr(i, 32'h0A0B0C0D, 4'h3);
            rd(ad(i), sh[i]);
        end
        rc(1'b0);
        rc(1'b1);
        $display("routing done");
        for (i = 0; i < 4; i++) begin
            wr(i, sh[i] | 32'h80000000);
            wr(i, 32'h01020304);
            rd(ad(i), sh[i]);
        end
        rc(1'b0);
        $display("lock done");
        rs();
        for (i = 0; i < 4; i++) begin
            wr(i, 32'h05060708);
            rd(ad(i), sh[i]);
        end
        $display("reset unlock done");
        stop_test();
    end
endmodule // test_timer_trigger_route_select
`default_nettype wire
